// file: rtl/fhl_link_flags.sv
// Top: link-wide run and trouble flags plus per-entry status arrays
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01 - One status bit per registered entry in each array, up to 64.
// RULE_02 - Run flag sets only with activation, valid config, exchange, remote run.
// RULE_03 - Run flag is sticky; only reset or activation off clears it.
// RULE_04 - With run flag set, trouble follows any violated run condition.
// RULE_05 - Health bit is exchange and remote-run and not fault.
// RULE_06 - Remote-run bit high only while remote station is in run mode.
// RULE_07 - Exchange bit high while entry exchanges within its configured cycle.
// RULE_08 - Fault bit high while remote reports it cannot run its program.
// RULE_09 - Flags refresh on a fixed evaluation interval, not per frame.
// RULE_10 - Cyclic link runs only after activation; activation may ride a load.
// RULE_11 - Run and trouble are bits; four per-entry arrays readable always.
// RULE_12 - Received frame counts for an entry only if block numbers match.
// RULE_13 - Block numbers lie in 0 to 31.
// RULE_14 - Reset or activation off clears per-entry bits and trouble.
module fhl_link_flags #(
  parameter int N_ENTRIES = fhl_pkg::FHL_MAX_ENTRIES,
  parameter int EVAL_CYCLES = fhl_pkg::FHL_EVAL_CYCLES,
  parameter int CYC_W = fhl_pkg::FHL_CYC_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic link_enable,
  input wire logic param_load,
  input wire logic param_load_enable,
  input wire logic [N_ENTRIES-1:0] entry_registered,
  input wire logic [N_ENTRIES-1:0] entry_cfg_valid,
  input wire logic [N_ENTRIES*5-1:0] entry_block,
  input wire logic [N_ENTRIES*CYC_W-1:0] entry_cycle,
  input wire logic rx_valid,
  input wire logic [4:0] rx_block,
  input wire logic [1:0] rx_mode,
  input wire logic rx_fault,
  output logic link_active,
  output logic eval_tick,
  output logic link_run_flag,
  output logic link_trouble_flag,
  output logic [N_ENTRIES-1:0] entry_exchange_ok_bits,
  output logic [N_ENTRIES-1:0] entry_remote_run_bits,
  output logic [N_ENTRIES-1:0] entry_fault_bits,
  output logic [N_ENTRIES-1:0] entry_health_bits
);
  import fhl_pkg::*;

  localparam int EW = $clog2(EVAL_CYCLES + 1);
  localparam logic [EW-1:0] EVAL_LAST = EW'(EVAL_CYCLES - 1);

  fhl_state_e state_q;
  logic [EW-1:0] eval_cnt_q;
  logic [N_ENTRIES-1:0] cfg_ok;
  logic cond_all;
  logic act_req;

  // ----------------------------------------
  // Activation, immediate or with a parameter load
  // ----------------------------------------
  assign act_req = link_enable || (param_load && param_load_enable); // RULE_10

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= FHL_ST_IDLE;
    end else if (ce) begin
      case (state_q)
        FHL_ST_IDLE: begin
          if (act_req) begin
            state_q <= FHL_ST_WAIT;
          end
        end
        FHL_ST_WAIT, FHL_ST_RUN: begin
          if (!link_enable && !(param_load && param_load_enable)) begin
            state_q <= FHL_ST_IDLE;
          end else if (eval_tick) begin
            state_q <= FHL_ST_RUN;
          end
        end
        default: begin
          state_q <= FHL_ST_IDLE;
        end
      endcase
    end
  end

  assign link_active = (state_q != FHL_ST_IDLE); // RULE_10

  // ----------------------------------------
  // Evaluation interval
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      eval_cnt_q <= '0;
    end else if (ce) begin
      if (!link_active || eval_cnt_q == EVAL_LAST) begin
        eval_cnt_q <= '0;
      end else begin
        eval_cnt_q <= eval_cnt_q + 1'b1;
      end
    end
  end

  assign eval_tick = ce && link_active && (eval_cnt_q == EVAL_LAST); // RULE_09

  // ----------------------------------------
  // Per-entry monitors
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_ENTRIES; gi++) begin : g_ent // RULE_01
      logic ex, rr, ft;
      // Block field is 5 bits wide, so 0..31 is enforced by width
      assign cfg_ok[gi] = entry_cfg_valid[gi]
        && (entry_block[gi*5 +: 5] <= FHL_BLK_MAX); // RULE_13
      fhl_entry_mon #(.CYC_W(CYC_W)) u_mon (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .link_on(link_active && entry_registered[gi]),
        .eval_tick(eval_tick),
        .rx_valid(rx_valid),
        .rx_block(rx_block),
        .rx_mode(rx_mode),
        .rx_fault(rx_fault),
        .cfg_block(entry_block[gi*5 +: 5]),
        .cfg_cycle(entry_cycle[gi*CYC_W +: CYC_W]),
        .exch_ok(ex),
        .remote_run(rr),
        .fault(ft)
      );
      assign entry_exchange_ok_bits[gi] = ex; // RULE_11
      assign entry_remote_run_bits[gi] = rr;
      assign entry_fault_bits[gi] = ft;
      assign entry_health_bits[gi] = ex && rr && !ft; // RULE_05
    end
  endgenerate

  // Unregistered entries are ignored, not counted as failures
  assign cond_all = link_active && (|entry_registered)
    && &(~entry_registered | (cfg_ok & entry_health_bits)); // RULE_02

  // ----------------------------------------
  // Link-wide flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      link_run_flag <= 1'b0;
    end else if (ce) begin
      if (!link_active) begin // RULE_03
        link_run_flag <= 1'b0;
      end else if (eval_tick && cond_all) begin // RULE_02
        link_run_flag <= 1'b1;
      end
    end
  end

  // Sampled one cycle after the tick so per-entry bits are the refreshed ones
  logic tick_d_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      tick_d_q <= 1'b0;
    end else if (ce) begin
      tick_d_q <= eval_tick;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      link_trouble_flag <= 1'b0;
    end else if (ce) begin
      if (!link_active) begin // RULE_14
        link_trouble_flag <= 1'b0;
      end else if (tick_d_q && link_run_flag) begin
        link_trouble_flag <= !cond_all; // RULE_04
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_drop;
    link_active ##1 (!link_active && ce);
  endsequence

  AST_RUN_STICKY: assert property (@(posedge clk) disable iff (srst) // RULE_03
    link_run_flag && link_active |=> link_run_flag || !link_active)
    else $error("run flag dropped while active");
  AST_RUN_CLEAR: assert property (@(posedge clk) disable iff (srst) // RULE_03
    s_drop |=> !link_run_flag)
    else $error("run flag not cleared on deactivation");
  AST_RUN_SET: assert property (@(posedge clk) disable iff (srst) // RULE_02
    $rose(link_run_flag) |-> $past(cond_all) && $past(eval_tick))
    else $error("run flag set without conditions");
  AST_TRBL_ONLY_RUN: assert property ( // RULE_04
    @(posedge clk) disable iff (srst) link_trouble_flag |-> link_run_flag)
    else $error("trouble without run flag");
  AST_TRBL_CLEAR: assert property (@(posedge clk) disable iff (srst) // RULE_04
    ce && tick_d_q && link_run_flag && link_active && cond_all
      |=> !link_trouble_flag)
    else $error("trouble not cleared after recovery");
  AST_RUN_RISE: assert property (@(posedge clk) disable iff (srst) // RULE_02
    link_active && eval_tick && cond_all |=> link_run_flag)
    else $error("run flag not raised with all conditions met");
  AST_TICK_PULSE: assert property (@(posedge clk) disable iff (srst) // RULE_09
    eval_tick |=> !eval_tick)
    else $error("evaluation tick longer than one cycle");
  AST_ACT_ON: assert property (@(posedge clk) disable iff (srst) // RULE_10
    ce && !link_active && act_req |=> link_active)
    else $error("activation request not taken");
  AST_TRBL_SET: assert property (@(posedge clk) disable iff (srst) // RULE_04
    ce && tick_d_q && link_run_flag && link_active && !cond_all
      |=> link_trouble_flag)
    else $error("trouble not raised");
  AST_HEALTH: assert property (@(posedge clk) disable iff (srst) // RULE_05
    entry_health_bits == (entry_exchange_ok_bits & entry_remote_run_bits
      & ~entry_fault_bits))
    else $error("health bits mismatch");
  AST_CLEAR_OFF: assert property (@(posedge clk) disable iff (srst) // RULE_14
    ce && !link_active |=> entry_health_bits == '0 && !link_trouble_flag)
    else $error("bits not cleared while inactive");
  // Deregistering an entry clears its bit at once, off the tick
  AST_PERIODIC: assert property (@(posedge clk) disable iff (srst) // RULE_09
    !$past(eval_tick) && link_active && $past(link_active)
      && $past(entry_registered) == $past(entry_registered, 2)
      |-> $stable(entry_exchange_ok_bits))
    else $error("exchange bits changed off tick");
  AST_START: assert property (@(posedge clk) disable iff (srst) // RULE_10
    !$past(act_req) && !$past(link_active) |-> !link_active)
    else $error("link started without activation");
endmodule

// file: common/fhl_pkg.sv
// Package: constants for the fast cyclic link health flag logic
package fhl_pkg;
  localparam int FHL_MAX_ENTRIES = 64;
  localparam int FHL_BLK_W = 5;
  localparam logic [4:0] FHL_BLK_MAX = 5'h1f;
  localparam int FHL_EVAL_TIME_US = 1000;
  localparam int FHL_CLK_MHZ = 100;
  localparam int FHL_EVAL_CYCLES = FHL_EVAL_TIME_US * FHL_CLK_MHZ;
  localparam int FHL_CYC_W = 32;
  localparam logic FHL_FLAG_RST = 1'b0;
  typedef enum logic [1:0] {
    FHL_RMODE_STOP = 2'b00,
    FHL_RMODE_RUN = 2'b01,
    FHL_RMODE_PAUSE = 2'b10,
    FHL_RMODE_DEBUG = 2'b11
  } fhl_rmode_e;
  typedef enum logic [1:0] {
    FHL_ST_IDLE = 2'b00,
    FHL_ST_WAIT = 2'b01,
    FHL_ST_RUN = 2'b10
  } fhl_state_e;
endpackage

// file: rtl/fhl_entry_mon.sv
// Per-entry monitor: block match, cycle deadline and status latches
`timescale 1ns/1ns
module fhl_entry_mon #(
  parameter int CYC_W = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic link_on,
  input wire logic eval_tick,
  input wire logic rx_valid,
  input wire logic [4:0] rx_block,
  input wire logic [1:0] rx_mode,
  input wire logic rx_fault,
  input wire logic [4:0] cfg_block,
  input wire logic [CYC_W-1:0] cfg_cycle,
  output logic exch_ok,
  output logic remote_run,
  output logic fault
);
  import fhl_pkg::*;

  logic hit;
  logic [CYC_W-1:0] age_q;
  logic seen_q;
  logic [1:0] mode_q;
  logic flt_q;

  assign hit = rx_valid && (rx_block == cfg_block); // RULE_12

  // ----------------------------------------
  // Frame age against configured cycle
  // ----------------------------------------
  // Clearing on link_on waits for ce, so ce low freezes every latch
  always_ff @(posedge clk) begin
    if (srst) begin
      age_q <= '0;
      seen_q <= 1'b0;
    end else if (ce) begin
      if (!link_on) begin
        age_q <= '0;
        seen_q <= 1'b0;
      end else if (hit) begin
        age_q <= '0;
        seen_q <= 1'b1;
      end else if (age_q != {CYC_W{1'b1}}) begin
        age_q <= age_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= FHL_RMODE_STOP;
      flt_q <= 1'b0;
    end else if (ce) begin
      if (!link_on) begin
        mode_q <= FHL_RMODE_STOP;
        flt_q <= 1'b0;
      end else if (hit) begin
        mode_q <= rx_mode;
        flt_q <= rx_fault;
      end
    end
  end

  // ----------------------------------------
  // Published bits, refreshed on eval tick
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin // RULE_14
      exch_ok <= FHL_FLAG_RST;
      remote_run <= FHL_FLAG_RST;
      fault <= FHL_FLAG_RST;
    end else if (ce) begin
      if (!link_on) begin // RULE_14
        exch_ok <= FHL_FLAG_RST;
        remote_run <= FHL_FLAG_RST;
        fault <= FHL_FLAG_RST;
      end else if (eval_tick) begin // RULE_09
        exch_ok <= seen_q && (age_q <= cfg_cycle); // RULE_07
        remote_run <= (mode_q == FHL_RMODE_RUN); // RULE_06
        fault <= flt_q; // RULE_08
      end
    end
  end
endmodule

// file: testbench/fhl_remote_model.sv
// Remote station model sending cyclic numbered data frames
`timescale 1ns/1ns
module fhl_remote_model (
  input wire logic clk,
  input wire logic send_en,
  input wire logic [4:0] blk_base,
  input wire logic [1:0] mode,
  input wire logic fault,
  output logic rx_valid,
  output logic [4:0] rx_block,
  output logic [1:0] rx_mode,
  output logic rx_fault
);
  import fhl_pkg::*;
  logic [2:0] seq_q = 3'h0;
  initial begin
    rx_valid = 1'b0;
    rx_block = 5'h0;
    rx_mode = 2'h0;
    rx_fault = 1'b0;
  end
  // One frame every two cycles, four blocks in turn
  always @(posedge clk) begin
    seq_q <= seq_q + 3'h1;
    rx_valid <= send_en && !seq_q[0];
    if (send_en && !seq_q[0]) begin
      // Caller keeps blk_base at or below 28
      rx_block <= blk_base + {3'h0, seq_q[2:1]};
      rx_mode <= mode;
      rx_fault <= fault;
    end else begin
      // Idle fields toggle so a stale frame cannot pass
      rx_block <= ~rx_block;
      rx_mode <= ~rx_mode;
      rx_fault <= ~rx_fault;
    end
  end
endmodule

// file: testbench/fhl_link_flags_tb.sv
// Self-checking bench for the link health flag logic
`timescale 1ns/1ns
module fhl_link_flags_tb;
  import fhl_pkg::*;
  localparam int N = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic link_enable = 1'b0;
  logic param_load = 1'b0;
  logic param_load_enable = 1'b0;
  logic [N-1:0] reg_m = 4'hf;
  logic [N-1:0] cfg_v = 4'hf;
  logic [N*5-1:0] blocks = {5'h3, 5'h2, 5'h1, 5'h0};
  logic [N*32-1:0] cycles = {N{32'hc}};
  logic send_en = 1'b0;
  logic [4:0] blk_base = 5'h0;
  logic [1:0] mode = FHL_RMODE_RUN;
  logic fault = 1'b0;
  logic rx_valid, rx_fault, link_active, eval_tick, run_f, trbl_f;
  logic [4:0] rx_block;
  logic [1:0] rx_mode;
  logic [N-1:0] xok, rrun, flt, hlth;
  fhl_rmode_e ml[4] = '{FHL_RMODE_STOP, FHL_RMODE_PAUSE, FHL_RMODE_DEBUG,
    FHL_RMODE_RUN};
  int bad_count = 0;
  int check_count = 0;

  fhl_link_flags #(.N_ENTRIES(N), .EVAL_CYCLES(16)) fhl_link_flags_inst (
    .clk, .srst, .ce, .link_enable, .param_load, .param_load_enable,
    .entry_registered(reg_m), .entry_cfg_valid(cfg_v), .entry_block(blocks),
    .entry_cycle(cycles), .rx_valid, .rx_block, .rx_mode, .rx_fault,
    .link_active, .eval_tick, .link_run_flag(run_f),
    .link_trouble_flag(trbl_f), .entry_exchange_ok_bits(xok),
    .entry_remote_run_bits(rrun), .entry_fault_bits(flt),
    .entry_health_bits(hlth));
  fhl_remote_model fhl_remote_model_inst (.clk, .send_en, .blk_base, .mode,
    .fault, .rx_valid, .rx_block, .rx_mode, .rx_fault);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic st(input logic [3:0] x, r, f, h, input logic rn, tr);
    check("run_vs_active", run_f & ~link_active, 8'h0);
    check("exchange_ok", xok, x);
    check("remote_run", rrun, r);
    check("fault", flt, f);
    check("health", hlth, h);
    check("run_flag", run_f, rn);
    check("trouble", trbl_f, tr);
  endtask
  // Returns one edge after the n-th tick edge, so trouble has settled
  task automatic ticks(input int n);
    int k;
    for (int t = 0; t < n; t++) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (eval_tick !== 1'b1 && k < 100);
      if (k >= 100) begin
        bad_count++;
      end
      @(posedge clk);
    end
    @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    forever begin
      #5;
      clk = ~clk;
    end
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    st(4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    @(posedge clk);
    send_en <= 1'b1;
    link_enable <= 1'b1;
    ticks(2);
    check("link_active", link_active, 8'h1);
    st(4'hf, 4'hf, 4'h0, 4'hf, 1'b1, 1'b0);
    // Clock enable low across two and a half intervals (40 cycles): no tick, no refresh
    @(posedge clk);
    ce <= 1'b0;
    mode <= FHL_RMODE_STOP;
    repeat (40) @(posedge clk);
    #1;
    check("eval_tick", eval_tick, 8'h0);
    st(4'hf, 4'hf, 4'h0, 4'hf, 1'b1, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mode <= ml[m];
      ticks(2);
      st(4'hf, (m == 3) ? 4'hf : 4'h0, 4'h0, (m == 3) ? 4'hf : 4'h0, 1'b1,
        m != 3);
    end
    @(posedge clk);
    fault <= 1'b1;
    ticks(2);
    st(4'hf, 4'hf, 4'hf, 4'h0, 1'b1, 1'b1);
    @(posedge clk);
    fault <= 1'b0;
    blk_base <= 5'h1c;
    ticks(2);
    check("exchange_ok", xok, 8'h0);
    check("health", hlth, 8'h0);
    check("trouble", trbl_f, 8'h1);
    @(posedge clk);
    blk_base <= 5'h0;
    ticks(2);
    @(posedge clk);
    mode <= FHL_RMODE_STOP;
    repeat (3) @(posedge clk);
    #1;
    check("remote_run", rrun, 8'hf);
    @(posedge clk);
    mode <= FHL_RMODE_RUN;
    link_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    st(4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    check("link_active", link_active, 8'h0);
    @(posedge clk);
    cfg_v <= 4'h7;
    link_enable <= 1'b1;
    ticks(2);
    check("run_flag", run_f, 8'h0);
    @(posedge clk);
    cfg_v <= 4'hf;
    reg_m <= 4'hb;
    ticks(2);
    check("exchange_ok", xok, 8'hb);
    check("health", hlth, 8'hb);
    @(posedge clk);
    link_enable <= 1'b0;
    repeat (3) @(posedge clk);
    param_load <= 1'b1;
    param_load_enable <= 1'b1;
    @(posedge clk);
    #1;
    check("link_active", link_active, 8'h1);
    @(posedge clk);
    param_load <= 1'b0;
    report_and_stop();
  end
endmodule
